// ===== bench/lipd_host_model.sv
// Host model issuing legacy I/O cycles
`timescale 1ns/1ps
module lipd_host_model (
  // Clock
  input  wire logic        clk,
  // Cycle
  output logic             ioValid,
  output logic             ioWrite,
  output logic [15:0]      ioAddr,
  output logic [7:0]       ioWdata
);
  // Idle bus
  initial begin
    ioValid = 1'b0;
    ioWrite = 1'b0;
    ioAddr  = 16'h0000;
    ioWdata = 8'h00;
  end

  // One edge per step; idle steps invert leftovers so stale values never match
  task automatic drive(input logic v, input logic w, input logic [15:0] a);
    @(posedge clk);
    ioValid <= v;
    ioWrite <= v ? w : ~ioWrite;
    ioAddr  <= v ? a : ~ioAddr;
    ioWdata <= v ? (a[7:0] ^ 8'h5a) : ~ioWdata;
  endtask
endmodule // lipd_host_model

// ===== bench/lipd_io_decoder_tb_top.sv
// Self-checking bench for the legacy I/O decoder
`timescale 1ns/1ps
module lipd_io_decoder_tb_top
  import lipd_pkg::*;
;
  // Route masks, pic1 at msb down to default at lsb
  localparam logic [9:0] PIC1 = 10'h200, PIC2 = 10'h100, TMR = 10'h080, NMI = 10'h040;
  localparam logic [9:0] RTC = 10'h020, RST = 10'h010, LPC = 10'h008, PCIE = 10'h004;
  localparam logic [9:0] RSV = 10'h002, DFLT = 10'h001;
  logic        clk, rst_n, ioValid, ioWrite, aliasEn, toPcie, outValid, outWrite;
  logic [15:0] ioAddr, outAddr;
  logic [7:0]  ioWdata, outWdata;
  lipd_route_s outRoute;
  int          failures, n_checks;
  logic [7:0]  lastWd;

  lipd_host_model lipd_host_model_i (.clk(clk), .ioValid(ioValid), .ioWrite(ioWrite),
    .ioAddr(ioAddr), .ioWdata(ioWdata));
  lipd_io_decoder lipd_io_decoder_i (.clk(clk), .rst_n(rst_n), .ioValid(ioValid),
    .ioWrite(ioWrite), .ioAddr(ioAddr), .ioWdata(ioWdata), .port61AliasEnable(aliasEn),
    .postToPcie(toPcie), .outValid(outValid), .outWrite(outWrite), .outAddr(outAddr),
    .outWdata(outWdata), .outRoute(outRoute));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ******************
  // Checking helpers
  // ******************
  task automatic cmp_route(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: route %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_cyc(input logic [25:0] got, input logic [25:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: cycle %h expected %h", $time, got, exp);
    end
  endtask
  // Address holds when idle; write data holds from the last write, reads leave it
  task automatic expect_out(input logic v, input logic w, input logic [15:0] a,
                            input logic [9:0] r);
    cmp_cyc({outValid, outWrite, outAddr, outWdata},
            {v, v & w, a, (v & w) ? (a[7:0] ^ 8'h5a) : lastWd});
    cmp_route(outRoute, r);
    if (v & w) lastWd = a[7:0] ^ 8'h5a;
  endtask
  task automatic chk(input logic [15:0] a, input logic w, input logic [9:0] r);
    lipd_host_model_i.drive(1'b1, w, a);
    lipd_host_model_i.drive(1'b0, 1'b0, 16'h0000);
    #1 expect_out(1'b1, w, a, r);
  endtask
  task automatic finish_test();
    $display("failures=%0d n_checks=%0d", failures, n_checks);
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ******************
  // Scenarios
  // ******************
  task automatic t_pic();
    chk(16'h0020, 1'b0, PIC1);
    chk(16'h003d, 1'b1, PIC1);
    chk(16'h0022, 1'b1, DFLT);
    chk(16'h0024, 1'b1, PIC1);
    chk(16'h0026, 1'b0, DFLT);
    chk(16'h00ad, 1'b0, PIC2);
    chk(16'h00a2, 1'b1, DFLT);
    chk(16'h00a0, 1'b1, PIC2);
    chk(16'h00b1, 1'b0, PIC2);
  endtask
  // Destination select high must not pull these off the LPC side
  task automatic t_lpc();
    @(posedge clk) toPcie <= 1'b1;
    chk(16'h002e, 1'b1, LPC);
    chk(16'h004f, 1'b0, LPC);
    chk(16'h0060, 1'b1, LPC);
    chk(16'h0066, 1'b0, LPC);
    chk(16'h0064, 1'b1, LPC);
    chk(16'h0098, 1'b1, LPC);
    chk(16'h0090, 1'b0, LPC);
    chk(16'h009e, 1'b1, LPC);
  endtask
  task automatic t_tmr();
    chk(16'h0040, 1'b0, TMR);
    chk(16'h0053, 1'b1, TMR);
    chk(16'h0043, 1'b1, TMR);
    chk(16'h0041, 1'b0, DFLT);
  endtask
  task automatic t_nmi();
    @(posedge clk) aliasEn <= 1'b0;
    chk(16'h0061, 1'b0, NMI);
    chk(16'h0063, 1'b1, PCIE);
    chk(16'h0065, 1'b0, PCIE);
    @(posedge clk) aliasEn <= 1'b1;
    chk(16'h0067, 1'b0, NMI);
    chk(16'h0065, 1'b1, NMI);
    chk(16'h0161, 1'b1, DFLT);
  endtask
  task automatic t_rtc();
    chk(16'h0070, 1'b0, RTC);
    chk(16'h0077, 1'b1, RTC);
    chk(16'h0073, 1'b0, RTC);
    chk(16'h0078, 1'b0, DFLT);
  endtask
  task automatic t_post();
    @(posedge clk) toPcie <= 1'b0;
    chk(16'h0080, 1'b1, LPC);
    chk(16'h0084, 1'b0, RSV);
    chk(16'h0085, 1'b0, RSV);
    chk(16'h008e, 1'b1, LPC);
    @(posedge clk) toPcie <= 1'b1;
    chk(16'h0080, 1'b0, PCIE);
    chk(16'h008c, 1'b1, PCIE);
    chk(16'h0088, 1'b1, PCIE);
  endtask
  // Back-to-back requests, then the idle cycle after
  task automatic t_b2b();
    lipd_host_model_i.drive(1'b1, 1'b1, 16'h0070);
    lipd_host_model_i.drive(1'b1, 1'b0, 16'h0092);
    #1 expect_out(1'b1, 1'b1, 16'h0070, NMI | RTC);
    lipd_host_model_i.drive(1'b0, 1'b0, 16'h0000);
    #1 expect_out(1'b1, 1'b0, 16'h0092, RST);
    @(posedge clk);
    #1 expect_out(1'b0, 1'b0, 16'h0092, 10'h000);
  endtask
  // Reset in mid-run wipes a captured cycle, then traffic resumes at once
  task automatic t_rst();
    lipd_host_model_i.drive(1'b1, 1'b1, 16'h0092);
    lipd_host_model_i.drive(1'b0, 1'b0, 16'h0000);
    rst_n <= 1'b0;
    lastWd = 8'h00;
    #1 expect_out(1'b0, 1'b0, 16'h0000, 10'h000);
    @(posedge clk) rst_n <= 1'b1;
    chk(16'h0021, 1'b1, PIC1);
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    aliasEn = 1'b0;
    toPcie = 1'b0;
    failures = 0;
    n_checks = 0;
    lastWd = 8'h00;
    repeat (5) @(posedge clk);
    #1 cmp_route(outRoute, 10'h000);
    @(posedge clk) rst_n <= 1'b1;
    t_pic();
    t_lpc();
    t_tmr();
    t_nmi();
    t_rtc();
    t_post();
    t_b2b();
    t_rst();
    finish_test();
  end

  // Watchdog
  initial begin
    #(40 * 5000);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule // lipd_io_decoder_tb_top

// ===== hdl/lipd_cfg.svh
// Port numbers and widths used by the fixed legacy I/O decoder
`ifndef LIPD_CFG_SVH
`define LIPD_CFG_SVH
`define LIPD_ADDR_W       16
`define LIPD_DATA_W       8
`define LIPD_PIC1_BASE    16'h0020
`define LIPD_PIC1_TOP     16'h003d
`define LIPD_PIC2_BASE    16'h00a0
`define LIPD_PIC2_TOP     16'h00b1
`define LIPD_CFG_IDX_LO   16'h002e
`define LIPD_CFG_IDX_HI   16'h004e
`define LIPD_TMR_LO       16'h0040
`define LIPD_TMR_HI       16'h0050
`define LIPD_KBD_DATA     16'h0060
`define LIPD_NMI_PORT     16'h0061
`define LIPD_RTC_INDEX    16'h0070
`define LIPD_RTC_TOP      16'h0077
`define LIPD_POST_PORT    16'h0080
`define LIPD_RST_PORT     16'h0092
`endif

// ===== hdl/lipd_decode.sv
// Combinational address-to-target map for fixed legacy I/O ports
`timescale 1ns/1ps
`include "lipd_cfg.svh"
module lipd_decode
  import lipd_pkg::*;
(
  // Cycle
  input  wire logic [15:0] addr,
  input  wire logic        isWrite,
  // Controls
  input  wire logic        port61AliasEnable,
  input  wire logic        postToPcie,
  // Result
  output lipd_route_s      route
);
  logic [7:0] lo;
  logic       upperZero;
  assign lo        = addr[7:0];
  assign upperZero = (addr[15:8] == 8'h00);

  // Fixed table; the upper byte must be zero for any fixed hit
  always_comb begin
    route = '0;
    if (upperZero) begin
      // Both controllers repeat every 4 ports, pairs at bit1 == 0
      if (addr >= `LIPD_PIC1_BASE && addr <= `LIPD_PIC1_TOP && !lo[1]) begin
        route.pic1 = 1'b1;
      end else if (addr >= `LIPD_PIC2_BASE && addr <= `LIPD_PIC2_TOP && !lo[1]) begin
        route.pic2 = 1'b1;
      end else if (addr[15:1] == `LIPD_CFG_IDX_LO >> 1 ||
                   addr[15:1] == `LIPD_CFG_IDX_HI >> 1) begin
        route.lpc = 1'b1;
      end else if (lo == 8'h40 || lo == 8'h42 || lo == 8'h43 ||
                   lo == 8'h50 || lo == 8'h52 || lo == 8'h53) begin
        route.timer = 1'b1;
      end else if (lo == 8'h60 || lo == 8'h62 || lo == 8'h64 || lo == 8'h66) begin
        route.lpc = 1'b1;
      end else if (lo == 8'h61) begin
        route.nmi = 1'b1;
      end else if (lo == 8'h63 || lo == 8'h65 || lo == 8'h67) begin
        // Aliases of the NMI port only count when enabled
        if (port61AliasEnable) begin
          route.nmi = 1'b1;
        end else begin
          route.pcie = 1'b1;
        end
      end else if (lo == 8'h70) begin
        route.rtc = 1'b1;
        route.nmi = isWrite;
      end else if (lo >= 8'h71 && lo <= 8'h77) begin
        route.rtc = 1'b1;
      end else if (lo == 8'h80) begin
        route.lpc  = !postToPcie;
        route.pcie = postToPcie;
      end else if ((lo >= 8'h84 && lo <= 8'h86) || lo == 8'h88 ||
                   (lo >= 8'h8c && lo <= 8'h8e)) begin
        // Reads here have no owner; writes follow the port 80h choice
        route.reserved = !isWrite;
        route.lpc      = isWrite && !postToPcie;
        route.pcie     = isWrite && postToPcie;
      end else if (lo == 8'h92) begin
        route.rstGen = 1'b1;
      end else if (lo == 8'h90 || (lo >= 8'h94 && lo <= 8'h96) || lo == 8'h98 ||
                   (lo >= 8'h9c && lo <= 8'h9e)) begin
        route.lpc = 1'b1;
      end else begin
        route.dflt = 1'b1;
      end
    end else begin
      route.dflt = 1'b1;
    end
  end
endmodule // lipd_decode

// ===== hdl/lipd_io_decoder.sv
// Top of the fixed legacy I/O port decoder
`timescale 1ns/1ps
`include "lipd_cfg.svh"
// Functional notes
// - Primary interrupt controller owns 20h-3Dh pairs at 4-port stride.
// - Secondary interrupt controller owns A0h-B1h pairs at 4-port stride.
// - Config index/data pairs 2Eh-2Fh and 4Eh-4Fh go downstream to LPC.
// - Ports 40h, 42h-43h, 50h, 52h-53h go to the interval timer.
// - Ports 60h, 62h, 64h, 66h go downstream to LPC.
// - Port 61h goes to the NMI controller; 63h, 65h, 67h are its aliases.
// - Aliases 63h/65h/67h reach NMI only with alias enable, else PCIe.
// - Port 70h reads go to RTC; writes go to NMI and RTC.
// - Ports 71h-77h go to the real-time clock.
// - Port 80h goes to LPC or PCIe by destination select.
// - Ports 84h-86h, 88h, 8Ch-8Eh: reads reserved, writes to LPC or PCIe.
// - Ports 90h, 94h-96h, 98h, 9Ch-9Eh alias 80h and go to LPC.
// - Port 92h goes to the reset generator.
module lipd_io_decoder
  import lipd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Host I/O cycle, one-cycle request
  input  wire logic        ioValid,
  input  wire logic        ioWrite,
  input  wire logic [15:0] ioAddr,
  input  wire logic [7:0]  ioWdata,
  // Controls
  input  wire logic        port61AliasEnable,
  input  wire logic        postToPcie,
  // Routed cycle, one cycle after request
  output logic             outValid,
  output logic             outWrite,
  output logic [15:0]      outAddr,
  output logic [7:0]       outWdata,
  output lipd_route_s      outRoute
);
  // ****************************************
  // Decode
  // ****************************************
  lipd_route_s route;

  lipd_decode uDecode (
    .addr              (ioAddr),
    .isWrite           (ioWrite),
    .port61AliasEnable (port61AliasEnable),
    .postToPcie        (postToPcie),
    .route             (route)
  );

  // ****************************************
  // Output registers
  // ****************************************
  logic        valid_r, valid_nxt;
  logic        write_r, write_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [7:0]  wdata_r, wdata_nxt;
  lipd_route_s route_r, route_nxt;

  // Route is zero between cycles so no unit sees a stale select
  always_comb begin
    valid_nxt = ioValid;
    write_nxt = ioValid && ioWrite;
    addr_nxt  = ioValid ? ioAddr : addr_r;
    wdata_nxt = (ioValid && ioWrite) ? ioWdata : wdata_r;
    route_nxt = ioValid ? route : '0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_r <= 1'b0;
      write_r <= 1'b0;
      addr_r  <= 16'h0000;
      wdata_r <= 8'h00;
      route_r <= '0;
    end else begin
      valid_r <= valid_nxt;
      write_r <= write_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      route_r <= route_nxt;
    end
  end

  assign outValid = valid_r;
  assign outWrite = write_r;
  assign outAddr  = addr_r;
  assign outWdata = wdata_r;
  assign outRoute = route_r;

  // ****************************************
  // Checks
  // ****************************************
  property p_pic1;
    @(posedge clk) disable iff (!rst_n)
    ioValid && ioAddr == 16'h0024 |=> outRoute.pic1 && !outRoute.lpc;
  endproperty
  a_pic1: assert property (p_pic1) else $error("pic1 miss");
  property p_pic2;
    @(posedge clk) disable iff (!rst_n)
    ioValid && ioAddr == 16'h00ad |=> outRoute.pic2;
  endproperty
  a_pic2: assert property (p_pic2) else $error("pic2 miss");
  property p_cfg;
    @(posedge clk) disable iff (!rst_n)
    ioValid && ioAddr == 16'h004f |=> outRoute.lpc && !outRoute.pic1;
  endproperty
  a_cfg: assert property (p_cfg) else $error("cfg miss");
  property p_tmr;
    @(posedge clk) disable iff (!rst_n)
    ioValid && (ioAddr == 16'h0041 || ioAddr == 16'h0051) |=> !outRoute.timer;
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer hole claimed");
  property p_alias;
    @(posedge clk) disable iff (!rst_n)
    ioValid && ioAddr == 16'h0065 |=> outRoute.nmi == $past(port61AliasEnable)
                                      && outRoute.pcie == !$past(port61AliasEnable);
  endproperty
  a_alias: assert property (p_alias) else $error("alias route wrong");
  property p_rtc70;
    @(posedge clk) disable iff (!rst_n)
    ioValid && ioAddr == 16'h0070 |=> outRoute.rtc && outRoute.nmi == outWrite;
  endproperty
  a_rtc70: assert property (p_rtc70) else $error("70h route wrong");
  property p_resv;
    @(posedge clk) disable iff (!rst_n)
    ioValid && !ioWrite && ioAddr == 16'h0085 |=> outRoute.reserved && !outRoute.lpc;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved read forwarded");
  property p_dflt;
    @(posedge clk) disable iff (!rst_n)
    ioValid && ioAddr[15:8] != 8'h00 |=> outRoute == 10'h001;
  endproperty
  a_dflt: assert property (p_dflt) else $error("high port claimed");
  property p_idle;
    @(posedge clk) disable iff (!rst_n)
    !ioValid |=> outRoute == 10'h000 && !outValid;
  endproperty
  a_idle: assert property (p_idle) else $error("idle route");
  // Keyboard controller ports stay on the downstream bus
  property p_kbc;
    @(posedge clk) disable iff (!rst_n)
    ioValid && ioAddr == 16'h0064 |=> outRoute == 10'h008;
  endproperty
  a_kbc: assert property (p_kbc) else $error("64h route wrong");
  // The base NMI port never depends on the alias enable
  property p_nmi61;
    @(posedge clk) disable iff (!rst_n)
    ioValid && ioAddr == 16'h0061 |=> outRoute == 10'h040;
  endproperty
  a_nmi61: assert property (p_nmi61) else $error("61h route wrong");
  // Data ports of the clock unit go nowhere else
  property p_rtcRange;
    @(posedge clk) disable iff (!rst_n)
    ioValid && ioAddr >= 16'h0071 && ioAddr <= 16'h0077 |=> outRoute == 10'h020;
  endproperty
  a_rtcRange: assert property (p_rtcRange) else $error("clock range wrong");
  // A read of the index port must not disturb the NMI logic
  property p_rtc70Rd;
    @(posedge clk) disable iff (!rst_n)
    ioValid && !ioWrite && ioAddr == 16'h0070 |=> outRoute == 10'h020;
  endproperty
  a_rtc70Rd: assert property (p_rtc70Rd) else $error("70h read reached NMI");
  // POST port follows the destination select seen with the request
  property p_post80;
    @(posedge clk) disable iff (!rst_n)
    ioValid && ioAddr == 16'h0080 |=> outRoute.pcie == $past(postToPcie)
                                      && outRoute.lpc == !$past(postToPcie);
  endproperty
  a_post80: assert property (p_post80) else $error("80h destination wrong");
  // Writes to the reserved-read ports still reach exactly one bus
  property p_resvWr;
    @(posedge clk) disable iff (!rst_n)
    ioValid && ioWrite && ioAddr == 16'h0088 |=> !outRoute.reserved && outRoute.lpc != outRoute.pcie;
  endproperty
  a_resvWr: assert property (p_resvWr) else $error("reserved write lost");
  // POST aliases ignore the destination select
  property p_alias80;
    @(posedge clk) disable iff (!rst_n)
    ioValid && ioAddr == 16'h0098 |=> outRoute == 10'h008;
  endproperty
  a_alias80: assert property (p_alias80) else $error("80h alias wrong");
  // Reset generator port is claimed internally
  property p_rstGen;
    @(posedge clk) disable iff (!rst_n)
    ioValid && ioAddr == 16'h0092 |=> outRoute == 10'h010;
  endproperty
  a_rstGen: assert property (p_rstGen) else $error("92h route wrong");
  // Timer control port
  property p_tmrHit;
    @(posedge clk) disable iff (!rst_n)
    ioValid && ioAddr == 16'h0043 |=> outRoute == 10'h080;
  endproperty
  a_tmrHit: assert property (p_tmrHit) else $error("43h route wrong");
  // Odd pairs inside the primary window other than 2Eh-2Fh belong to nobody
  property p_pic1Hole;
    @(posedge clk) disable iff (!rst_n)
    ioValid && ioAddr == 16'h0026 |=> outRoute == 10'h001;
  endproperty
  a_pic1Hole: assert property (p_pic1Hole) else $error("26h claimed");
  // Same for the secondary window
  property p_pic2Hole;
    @(posedge clk) disable iff (!rst_n)
    ioValid && ioAddr == 16'h00a2 |=> outRoute == 10'h001;
  endproperty
  a_pic2Hole: assert property (p_pic2Hole) else $error("a2h claimed");
  // Every accepted cycle lands on some target, the default path included
  property p_claim;
    @(posedge clk) disable iff (!rst_n)
    ioValid |=> outValid && outRoute != 10'h000;
  endproperty
  a_claim: assert property (p_claim) else $error("cycle without target");

  // ****************************************
  // Coverage
  // ****************************************
  c_nmi: cover property (@(posedge clk) ioValid && ioAddr == 16'h0061);
  c_post: cover property (@(posedge clk) ioValid && ioAddr == 16'h0080 && postToPcie);
  c_rst: cover property (@(posedge clk) ioValid && ioAddr == 16'h0092 && ioWrite);
  c_alias: cover property (@(posedge clk) ioValid && ioAddr == 16'h0065 && port61AliasEnable);
  c_resv: cover property (@(posedge clk) ioValid && !ioWrite && ioAddr == 16'h0084);
endmodule // lipd_io_decoder

// ===== hdl/lipd_pkg.sv
// Types shared by the legacy I/O decoder files
package lipd_pkg;
  // Set of routing targets for a single cycle; one bit set, except two for 70h writes
  typedef struct packed {
    logic pic1;
    logic pic2;
    logic timer;
    logic nmi;
    logic rtc;
    logic rstGen;
    logic lpc;
    logic pcie;
    logic reserved;
    logic dflt;
  } lipd_route_s;

  // Decode result classes
  typedef enum logic [1:0] {
    LIPD_IDLE = 2'b00,
    LIPD_HIT  = 2'b01,
    LIPD_MISS = 2'b10
  } lipd_state_e;
endpackage
